/* File: hdl/crcg_pkg.sv */
// package: register map, field layout, reset values and types of the crc generator
package crcg_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL_ONE = 5'h00; // crc_control_one
  localparam logic [4:0] OFS_CTRL_TWO = 5'h04; // crc_control_two
  localparam logic [4:0] OFS_POLY_HIGH = 5'h08; // poly_terms_high
  localparam logic [4:0] OFS_POLY_LOW = 5'h0C; // poly_terms_low
  localparam logic [4:0] OFS_DATA_IN = 5'h10; // data_input_word, write pushes fifo
  localparam logic [4:0] OFS_RESULT = 5'h14; // result_word
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h18; // sticky events, write one to clear
  localparam logic [4:0] OFS_IRQ_MASK = 5'h1C; // interrupt mask
  // ----------------------------------------------------------------
  // crc_control_one fields
  // ----------------------------------------------------------------
  localparam int BIT_MODULE_ON = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int POS_WORD_COUNT = 8; // five-bit count at 12:8
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SEL = 5;
  localparam int BIT_RUN = 4;
  localparam int BIT_LSB_FIRST = 3;
  // ----------------------------------------------------------------
  // crc_control_two fields
  // ----------------------------------------------------------------
  localparam int POS_DATA_WIDTH = 8; // five bits at 12:8
  localparam int POS_POLY_LEN = 0; // five bits at 4:0
  // ----------------------------------------------------------------
  // status bits, fifo limits, reset values
  // ----------------------------------------------------------------
  localparam int BIT_EVT_CRC = 0; // selected crc event
  localparam int BIT_EVT_OVERFLOW = 1; // write to a full fifo was dropped
  localparam logic [4:0] LONG_POLY_LIMIT = 5'h07; // above this, half depth
  localparam logic [4:0] MAX_WORDS_LONG = 5'h08;
  localparam logic [4:0] MAX_WORDS_SHORT = 5'h10;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } crcg_state_t;
  // engine configuration, gathered from the control registers
  typedef struct packed {
    logic lsb_first_select;
    logic [4:0] data_width_field;
    logic [4:0] poly_length_field;
    logic [31:0] taps;
  } crcg_cfg_t;
endpackage

/* File: hdl/crcg_top.sv */
// crc generator: avalon-mm register slave, data fifo, serial shift engine, interrupt
//
// Overview of operation
// - disable clears engine, fifo, data and result
// - idle-stop halts operation while chip idles
// - word count reports fifo fill, max 8/16
// - full flag set at maximum fill
// - empty flag set when fifo empty, resets one
// - select set: interrupt when fifo becomes empty
// - select clear: interrupt when shifting completes
// - run bit shifts fifo data; clearing stops
// - lsb-first select picks bit feed order
// - data word width is field plus one
// - polynomial length is field plus one
// - high register enables taps 16 to 31
// - set term bit inserts xor on bit
// - zero term and top term always applied
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module crcg_top #(
  parameter int FIFO_DEPTH = 16, // words of storage
  parameter int WORD_W = 32 // fifo word width
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // avalon-mm slave
  input wire logic [4:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // chip power state
  input wire logic idle_mode_in,
  // interrupts
  output logic irq_out,
  output logic irq_pulse_out
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (FIFO_DEPTH != 16) begin
    $error("fifo depth must be 16");
  end
  if (WORD_W != 32) begin
    $error("fifo word width must be 32");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // merge write data into a 16-bit register under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // one serial step of the engine, masked to the active length
  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
                                           input crcg_pkg::crcg_cfg_t cfg);
    logic fb;
    logic [31:0] nxt;
    logic [31:0] len_mask;
    fb = crc[cfg.poly_length_field] ^ din; // top term always in the loop
    nxt = {crc[30:0], 1'b0} ^ ({32{fb}} & cfg.taps); // tap xor per term
    nxt[0] = fb; // zero term always applied
    len_mask = 32'hFFFF_FFFF >> (5'd31 - cfg.poly_length_field);
    crc_step = nxt & len_mask;
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic module_on_reg; // enable
  logic idle_stop_reg; // stop in idle
  logic irq_source_select_reg; // interrupt source
  logic shifter_run_reg; // start shifter
  logic lsb_first_select_reg; // bit order
  logic [4:0] data_width_field_reg; // width minus one
  logic [4:0] poly_length_field_reg; // length minus one
  logic [15:0] poly_terms_high_reg; // taps 31:16
  logic [15:1] poly_terms_low_reg; // taps 15:1
  logic [31:0] result_word_reg; // engine register
  logic [1:0] irq_status_reg; // sticky events
  logic [1:0] irq_mask_reg; // event mask
  logic [31:0] fifo_mem [FIFO_DEPTH]; // fifo storage
  logic [3:0] head_reg; // read pointer
  logic [3:0] tail_reg; // write pointer
  logic [4:0] fifo_word_count_reg; // valid words
  crcg_pkg::crcg_state_t state_reg; // engine state
  logic [31:0] shift_word_reg; // word under shift
  logic [4:0] bit_cnt_reg; // bits shifted so far
  logic waitrequest_reg; // bus stall
  logic [31:0] readdata_reg; // bus read data
  logic irq_reg; // level interrupt
  logic irq_pulse_reg; // event pulse

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  logic bus_req; // request pending
  logic [15:0] low_merged; // low terms merged with bit zero
  logic wr_done; // write completes this edge
  logic [4:0] max_words; // fill limit for current length
  logic fifo_full; // at limit
  logic fifo_empty; // no words
  logic push; // accept a data word
  logic pop; // engine takes a word
  logic overflow; // data write dropped
  logic active; // engine may advance
  logic word_end; // last bit of a word
  logic evt_empty; // fifo has just drained
  logic evt_done; // final word shifted
  logic evt_sel; // selected crc event
  logic data_bit; // next bit into engine
  crcg_pkg::crcg_cfg_t cfg; // engine config

  assign bus_req = read_in | write_in;
  assign low_merged = merge16({poly_terms_low_reg, 1'b0}, writedata_in, byteenable_in);
  assign wr_done = write_in & ~waitrequest_reg;
  // long polynomials get half the depth
  assign max_words = (poly_length_field_reg > crcg_pkg::LONG_POLY_LIMIT) ?
                     crcg_pkg::MAX_WORDS_LONG : crcg_pkg::MAX_WORDS_SHORT;
  assign fifo_full = (fifo_word_count_reg >= max_words);
  assign fifo_empty = (fifo_word_count_reg == 5'd0);
  // each data write pushes one word while enabled; a write to a full fifo is dropped
  assign push = wr_done & (address_in == crcg_pkg::OFS_DATA_IN) & module_on_reg & ~fifo_full;
  assign overflow = wr_done & (address_in == crcg_pkg::OFS_DATA_IN) & module_on_reg & fifo_full;
  // halted while chip idles with idle-stop set, runs only with run bit
  assign active = module_on_reg & shifter_run_reg & ~(idle_stop_reg & idle_mode_in);
  assign pop = active & (state_reg == crcg_pkg::ST_IDLE) & ~fifo_empty;
  assign word_end = active & (state_reg == crcg_pkg::ST_SHIFT) &
                    (bit_cnt_reg == data_width_field_reg); // width is field plus one
  // drained while last word still shifts
  assign evt_empty = pop & (fifo_word_count_reg == 5'd1) & ~push;
  // shifting finished with nothing left
  assign evt_done = word_end & fifo_empty;
  assign evt_sel = irq_source_select_reg ? evt_empty : evt_done;

  // bit feed order
  always_comb begin
    data_bit = 1'b0;
    if (lsb_first_select_reg) begin
      data_bit = shift_word_reg[bit_cnt_reg];
    end else begin
      data_bit = shift_word_reg[data_width_field_reg - bit_cnt_reg];
    end
  end

  // tap vector from the term registers, bit zero implicit
  always_comb begin
    cfg.lsb_first_select = lsb_first_select_reg;
    cfg.data_width_field = data_width_field_reg;
    cfg.poly_length_field = poly_length_field_reg;
    cfg.taps = {poly_terms_high_reg, poly_terms_low_reg, 1'b0};
  end

  // ----------------------------------------------------------------
  // avalon handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      waitrequest_reg <= 1'b1;
    end else if (bus_req & waitrequest_reg) begin
      waitrequest_reg <= 1'b0; // release for the completing edge
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // read mux, captured during the wait cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      readdata_reg <= crcg_pkg::RST_WORD;
    end else if (read_in & waitrequest_reg) begin
      if (address_in == crcg_pkg::OFS_CTRL_ONE) begin
        readdata_reg <= crcg_pkg::RST_WORD;
        readdata_reg[crcg_pkg::BIT_MODULE_ON] <= module_on_reg;
        readdata_reg[crcg_pkg::BIT_IDLE_STOP] <= idle_stop_reg;
        readdata_reg[crcg_pkg::POS_WORD_COUNT +: 5] <= fifo_word_count_reg;
        readdata_reg[crcg_pkg::BIT_FULL] <= fifo_full;
        readdata_reg[crcg_pkg::BIT_EMPTY] <= fifo_empty;
        readdata_reg[crcg_pkg::BIT_IRQ_SEL] <= irq_source_select_reg;
        readdata_reg[crcg_pkg::BIT_RUN] <= shifter_run_reg;
        readdata_reg[crcg_pkg::BIT_LSB_FIRST] <= lsb_first_select_reg;
      end else if (address_in == crcg_pkg::OFS_CTRL_TWO) begin
        readdata_reg <= crcg_pkg::RST_WORD;
        readdata_reg[crcg_pkg::POS_DATA_WIDTH +: 5] <= data_width_field_reg;
        readdata_reg[crcg_pkg::POS_POLY_LEN +: 5] <= poly_length_field_reg;
      end else if (address_in == crcg_pkg::OFS_POLY_HIGH) begin
        readdata_reg <= {16'h0000, poly_terms_high_reg};
      end else if (address_in == crcg_pkg::OFS_POLY_LOW) begin
        readdata_reg <= {16'h0000, poly_terms_low_reg, 1'b0}; // bit zero reads zero
      end else if (address_in == crcg_pkg::OFS_RESULT) begin
        readdata_reg <= result_word_reg;
      end else if (address_in == crcg_pkg::OFS_IRQ_STATUS) begin
        readdata_reg <= {30'h0000_0000, irq_status_reg};
      end else if (address_in == crcg_pkg::OFS_IRQ_MASK) begin
        readdata_reg <= {30'h0000_0000, irq_mask_reg};
      end else begin
        readdata_reg <= crcg_pkg::RST_WORD; // data input and unmapped read zero
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers, untouched by the enable bit
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      module_on_reg <= 1'b0;
      idle_stop_reg <= 1'b0;
      irq_source_select_reg <= 1'b0;
      shifter_run_reg <= 1'b0;
      lsb_first_select_reg <= 1'b0;
      data_width_field_reg <= 5'h00;
      poly_length_field_reg <= 5'h00;
      poly_terms_high_reg <= crcg_pkg::RST_REG16;
      poly_terms_low_reg <= 15'h0000;
      irq_mask_reg <= crcg_pkg::RST_IRQ;
    end else if (wr_done) begin
      if (address_in == crcg_pkg::OFS_CTRL_ONE) begin
        if (byteenable_in[1]) begin
          module_on_reg <= writedata_in[crcg_pkg::BIT_MODULE_ON];
          idle_stop_reg <= writedata_in[crcg_pkg::BIT_IDLE_STOP];
        end
        if (byteenable_in[0]) begin
          irq_source_select_reg <= writedata_in[crcg_pkg::BIT_IRQ_SEL];
          shifter_run_reg <= writedata_in[crcg_pkg::BIT_RUN];
          lsb_first_select_reg <= writedata_in[crcg_pkg::BIT_LSB_FIRST];
        end
      end else if (address_in == crcg_pkg::OFS_CTRL_TWO) begin
        if (byteenable_in[1]) begin
          data_width_field_reg <= writedata_in[crcg_pkg::POS_DATA_WIDTH +: 5];
        end
        if (byteenable_in[0]) begin
          poly_length_field_reg <= writedata_in[crcg_pkg::POS_POLY_LEN +: 5];
        end
      end else if (address_in == crcg_pkg::OFS_POLY_HIGH) begin
        poly_terms_high_reg <= merge16(poly_terms_high_reg, writedata_in, byteenable_in);
      end else if (address_in == crcg_pkg::OFS_POLY_LOW) begin
        poly_terms_low_reg <= low_merged[15:1]; // bit zero dropped
      end else if (address_in == crcg_pkg::OFS_IRQ_MASK) begin
        if (byteenable_in[0]) begin
          irq_mask_reg <= writedata_in[1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fifo storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      fifo_mem[tail_reg] <= writedata_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      head_reg <= 4'h0;
      tail_reg <= 4'h0;
      fifo_word_count_reg <= 5'h00;
    end else if (!module_on_reg) begin
      head_reg <= 4'h0; // pointers cleared while disabled
      tail_reg <= 4'h0;
      fifo_word_count_reg <= 5'h00;
    end else begin
      if (push) begin
        tail_reg <= tail_reg + 4'h1;
      end
      if (pop) begin
        head_reg <= head_reg + 4'h1;
      end
      if (push & ~pop) begin
        fifo_word_count_reg <= fifo_word_count_reg + 5'h01;
      end else if (pop & ~push) begin
        fifo_word_count_reg <= fifo_word_count_reg - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= crcg_pkg::ST_IDLE;
      shift_word_reg <= crcg_pkg::RST_WORD;
      bit_cnt_reg <= 5'h00;
      result_word_reg <= crcg_pkg::RST_WORD;
    end else if (!module_on_reg) begin
      state_reg <= crcg_pkg::ST_IDLE; // engine and result cleared
      shift_word_reg <= crcg_pkg::RST_WORD;
      bit_cnt_reg <= 5'h00;
      result_word_reg <= crcg_pkg::RST_WORD;
    end else begin
      case (state_reg)
        crcg_pkg::ST_IDLE: begin
          if (pop) begin
            shift_word_reg <= fifo_mem[head_reg]; // engine takes head word
            bit_cnt_reg <= 5'h00;
            state_reg <= crcg_pkg::ST_SHIFT;
          end else if (wr_done && address_in == crcg_pkg::OFS_RESULT) begin
            result_word_reg <= writedata_in; // seed the engine between words
          end
        end
        crcg_pkg::ST_SHIFT: begin
          if (active) begin
            result_word_reg <= crc_step(result_word_reg, data_bit, cfg);
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (word_end) begin
              state_reg <= crcg_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= crcg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status_reg <= crcg_pkg::RST_IRQ;
    end else begin
      // write one clears, a new event in the same cycle wins
      if (wr_done && address_in == crcg_pkg::OFS_IRQ_STATUS && byteenable_in[0]) begin
        irq_status_reg <= (irq_status_reg & ~writedata_in[1:0]) | {overflow, evt_sel};
      end else begin
        irq_status_reg <= irq_status_reg | {overflow, evt_sel};
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_reg <= 1'b0;
      irq_pulse_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
      irq_pulse_reg <= evt_sel; // single-cycle request
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata_out = readdata_reg;
  assign waitrequest_out = waitrequest_reg;
  assign irq_out = irq_reg;
  assign irq_pulse_out = irq_pulse_reg;
endmodule

/* File: bench/crcg_assertions.sv */
// checker: bus handshake, read-back layout and interrupt timing of the crc generator
`timescale 1ns/1ps
module crcg_assertions #(
  parameter int FIFO_DEPTH = 16, // words of storage
  parameter int WORD_W = 32 // fifo word width
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // avalon-mm slave
  input wire logic [4:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  // chip power state and interrupts
  input wire logic idle_mode_in,
  input wire logic irq_out,
  input wire logic irq_pulse_out
);
  // read completing in this cycle
  wire rd_ok = read_in && !waitrequest_out;
  // ----------------------------------------------------------------
  // one clock domain
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // wait released for exactly one cycle
  property p_wait_short;
    !waitrequest_out |=> waitrequest_out;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("waitrequest low too long");
  // release only after a pending request
  property p_wait_cause;
    !waitrequest_out |-> $past(read_in || write_in) && $past(waitrequest_out);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("waitrequest low unasked");
  // a pending request is answered next cycle
  property p_wait_answer;
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  // event pulse lasts one cycle
  property p_pulse_single;
    irq_pulse_out |=> !irq_pulse_out;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("pulse too long");
  // data input word reads as zero
  property p_data_zero;
    rd_ok && address_in == crcg_pkg::OFS_DATA_IN |-> readdata_out == 32'h0000_0000;
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("data word read not zero");
  // empty flag tracks a zero count, count at most sixteen
  property p_empty_flag;
    rd_ok && address_in == crcg_pkg::OFS_CTRL_ONE |->
      readdata_out[6] == (readdata_out[12:8] == 5'h00) && readdata_out[12:8] <= 5'h10;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty or count wrong");
  // full flag only with at least eight words
  property p_full_flag;
    rd_ok && address_in == crcg_pkg::OFS_CTRL_ONE && readdata_out[7] |->
      readdata_out[12:8] >= 5'h08;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag with few words");
  // low term bit zero reads zero
  property p_low_bit0;
    rd_ok && address_in == crcg_pkg::OFS_POLY_LOW |-> readdata_out[0] == 1'b0;
  endproperty
  a_low_bit0: assert property (p_low_bit0) else $error("term bit zero set");
  // unused bits of control two read zero
  property p_ctrl_two_gaps;
    rd_ok && address_in == crcg_pkg::OFS_CTRL_TWO |->
      (readdata_out & 32'hFFFF_E0E0) == 32'h0000_0000;
  endproperty
  a_ctrl_two_gaps: assert property (p_ctrl_two_gaps) else $error("gap bits set");
  // interrupt level holds until software writes
  property p_irq_sticky;
    irq_out && !write_in && !$past(write_in) |=> irq_out;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped");
endmodule

/* File: bench/tb_top.sv */
// testbench: register, fifo, engine and interrupt scenarios of the crc generator
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // design inputs and outputs, counters
  // ----------------------------------------------------------------
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [4:0] address_in = 5'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [3:0] byteenable_in = 4'hF; // all lanes
  logic idle_mode_in = 1'b0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic irq_out;
  logic irq_pulse_out;
  int n_errors = 0;
  int cmp_count = 0;
  int n_pulse = 0; // event pulses seen
  int cycles = 0; // timeout counter
  // clock at 20 mhz
  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  crcg_top #(.FIFO_DEPTH(16), .WORD_W(32)) u_crcg_top (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .idle_mode_in(idle_mode_in),
    .irq_out(irq_out), .irq_pulse_out(irq_pulse_out));
  // pulse counting and hang guard
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (irq_pulse_out === 1'b1) begin
      n_pulse <= n_pulse + 1;
    end
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= ~wr;
    do @(posedge sys_clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask
  // bitwise reference of the shift engine, sixteen-bit ccitt terms
  function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [7:0] d,
                                          input logic lsb);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[15] ^ (lsb ? d[i] : d[7 - i]);
      c = {c[30:0], 1'b0} ^ (fb ? 32'h0000_1021 : 32'h0000_0000);
    end
    return c & 32'h0000_FFFF;
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values of all eight registers
  task automatic s_reset();
    for (int i = 0; i < 8; i++) begin
      rd_chk(5'(i * 4), (i == 0) ? 32'h0000_0040 : 32'h0000_0000);
    end
  endtask
  // access kinds and unused bits
  task automatic s_regs();
    wr(crcg_pkg::OFS_POLY_LOW, 32'hFFFF_FFFF);
    rd_chk(crcg_pkg::OFS_POLY_LOW, 32'h0000_FFFE);
    wr(crcg_pkg::OFS_POLY_HIGH, 32'hFFFF_FFFF);
    rd_chk(crcg_pkg::OFS_POLY_HIGH, 32'h0000_FFFF);
    wr(crcg_pkg::OFS_CTRL_TWO, 32'hFFFF_FFFF);
    rd_chk(crcg_pkg::OFS_CTRL_TWO, 32'h0000_1F1F);
    wr(crcg_pkg::OFS_CTRL_ONE, 32'h0000_FFFF);
    rd_chk(crcg_pkg::OFS_CTRL_ONE, 32'h0000_A078);
    wr(crcg_pkg::OFS_CTRL_ONE, 32'h0000_0000);
  endtask
  // fifo limits, overflow and disable
  task automatic s_fifo();
    wr(crcg_pkg::OFS_CTRL_TWO, 32'h0000_070F);
    wr(crcg_pkg::OFS_CTRL_ONE, 32'h0000_8000);
    for (int i = 0; i < 9; i++) begin
      wr(crcg_pkg::OFS_DATA_IN, 32'(i));
    end
    rd_chk(crcg_pkg::OFS_CTRL_ONE, 32'h0000_8880);
    rd_chk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    wr(crcg_pkg::OFS_CTRL_TWO, 32'h0000_0707);
    rd_chk(crcg_pkg::OFS_CTRL_ONE, 32'h0000_8800);
    for (int i = 0; i < 8; i++) begin
      wr(crcg_pkg::OFS_DATA_IN, 32'(i));
    end
    rd_chk(crcg_pkg::OFS_CTRL_ONE, 32'h0000_9080);
    wr(crcg_pkg::OFS_CTRL_ONE, 32'h0000_0000);
    rd_chk(crcg_pkg::OFS_CTRL_ONE, 32'h0000_0040);
    rd_chk(crcg_pkg::OFS_CTRL_TWO, 32'h0000_0707);
    wr(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
  endtask
  // two bytes through the engine, with bit order, event source and idle stop
  task automatic s_crc(input logic lsb, input logic sel, input logic idle);
    logic [31:0] cfg;
    logic [31:0] c;
    int p0;
    cfg = {16'h0000, 1'h1, 1'h0, idle, 5'h00, 2'h0, sel, 1'h0, lsb, 3'h0};
    c = ref_crc(ref_crc(32'h0000_FFFF, 8'h31, lsb), 8'hC2, lsb);
    wr(crcg_pkg::OFS_CTRL_TWO, 32'h0000_070F);
    wr(crcg_pkg::OFS_POLY_HIGH, 32'h0000_0000);
    wr(crcg_pkg::OFS_POLY_LOW, 32'h0000_1021);
    wr(crcg_pkg::OFS_IRQ_MASK, {31'h0000_0000, ~sel});
    wr(crcg_pkg::OFS_CTRL_ONE, cfg);
    wr(crcg_pkg::OFS_RESULT, 32'h0000_FFFF);
    wr(crcg_pkg::OFS_DATA_IN, 32'h0000_0131);
    wr(crcg_pkg::OFS_DATA_IN, 32'h0000_00C2);
    idle_mode_in <= 1'b1; // chip idles; runs on unless idle-stop is set
    p0 = n_pulse;
    wr(crcg_pkg::OFS_CTRL_ONE, cfg | 32'h0000_0010);
    if (idle) begin
      repeat (40) @(posedge sys_clk_in);
      rd_chk(crcg_pkg::OFS_CTRL_ONE, cfg | 32'h0000_0210);
      idle_mode_in <= 1'b0;
    end
    while (n_pulse == p0) @(posedge sys_clk_in);
    check({31'h0000_0000, irq_out}, {31'h0000_0000, ~sel});
    if (sel) begin
      rd_chk(crcg_pkg::OFS_CTRL_ONE, cfg | 32'h0000_0050);
      repeat (12) @(posedge sys_clk_in);
    end
    rd_chk(crcg_pkg::OFS_RESULT, c);
    rd_chk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    check(32'(n_pulse - p0), 32'h0000_0001);
    wr(crcg_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_in);
    check({31'h0000_0000, irq_out}, 32'h0000_0001);
    wr(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_in);
    check({31'h0000_0000, irq_out}, 32'h0000_0000);
    wr(crcg_pkg::OFS_CTRL_ONE, 32'h0000_0000);
    rd_chk(crcg_pkg::OFS_RESULT, 32'h0000_0000);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    s_reset();
    s_regs();
    s_fifo();
    s_crc(1'h0, 1'h0, 1'h1);
    s_crc(1'h1, 1'h1, 1'h0);
    stop_test();
  end
endmodule
bind crcg_top crcg_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .WORD_W(WORD_W)) u_crcg_assertions (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
  .byteenable_in(byteenable_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .idle_mode_in(idle_mode_in),
  .irq_out(irq_out), .irq_pulse_out(irq_pulse_out));
